// file: hw/vac_pkg.sv
// vac_pkg: shared constants of the attribute controller
package vac_pkg;
   // host I/O port addresses
   localparam logic [15:0] VAC_ADDR_ATTR_WR   = 16'h03C0;
   localparam logic [15:0] VAC_ADDR_ATTR_RD   = 16'h03C1;
   localparam logic [15:0] VAC_ADDR_STAT_MONO = 16'h03BA;
   localparam logic [15:0] VAC_ADDR_STAT_COLR = 16'h03DA;

   // attribute register indices
   localparam logic [4:0]  VAC_IDX_PAL_LAST   = 5'h0F;
   localparam logic [4:0]  VAC_IDX_MODE       = 5'h10;
   localparam logic [4:0]  VAC_IDX_BORDER     = 5'h11;
   localparam logic [4:0]  VAC_IDX_PAN        = 5'h13;
   localparam logic [4:0]  VAC_IDX_PAD        = 5'h14;

   // field positions
   localparam int          VAC_IDX_PAL_EN     = 5;
   localparam int          VAC_MODE_TXGR      = 0;
   localparam int          VAC_MODE_MONO      = 1;
   localparam int          VAC_MODE_LGC       = 2;
   localparam int          VAC_MODE_BLNK      = 3;
   localparam int          VAC_MODE_SPLIT     = 5;
   localparam int          VAC_MODE_WIDE      = 6;
   localparam int          VAC_MODE_SELV54    = 7;

   // reset values and writable masks
   localparam logic [5:0]  VAC_INDEX_RST      = 6'h00;
   localparam logic [7:0]  VAC_MODE_RST       = 8'h00;
   localparam logic [7:0]  VAC_MODE_WMASK     = 8'hEF;
   localparam logic [7:0]  VAC_BORDER_RST     = 8'h00;
   localparam logic [3:0]  VAC_PAN_RST        = 4'h0;
   localparam logic [3:0]  VAC_PAD_RST        = 4'h0;
   localparam logic [5:0]  VAC_PAL_RST        = 6'h00;

   // line-graphics character codes share these top bits
   localparam logic [2:0]  VAC_LG_TOP         = 3'h6;
   // mono attribute bits that decide blanking and underline
   localparam logic [7:0]  VAC_MONO_BLANK_MSK = 8'h77;
   localparam logic [2:0]  VAC_MONO_ULINE     = 3'h1;

   // blink divider: retraces per character blink period
   localparam int          VAC_BLINK_DIV      = 32;
   localparam int          VAC_CURSOR_DIV     = 16;
endpackage

// file: hw/vac_blink.sv
// vac_blink: retrace-driven blink divider for characters and cursor
`timescale 1ns/1ps
module vac_blink
   import vac_pkg::*;
#(
   parameter int CHAR_DIV   = VAC_BLINK_DIV,
   parameter int CURSOR_DIV = VAC_CURSOR_DIV
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic retrace_in,
   output logic      char_phase,
   output logic      cursor_phase
);
   localparam int CW = $clog2(CHAR_DIV);
   localparam int KB = $clog2(CURSOR_DIV) - 1;

   logic [CW-1:0] cnt_reg;
   logic          retrace_q_reg;
   logic          rise;

   // one count per retrace start, not per cycle of retrace
   assign rise = retrace_in && !retrace_q_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_reg       <= '0;
         retrace_q_reg <= 1'b0;
      end else begin
         retrace_q_reg <= retrace_in;
         if (rise) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   // top bit: on sixteen, off sixteen; lower bit gives the cursor rate
   assign char_phase   = cnt_reg[CW-1];
   assign cursor_phase = cnt_reg[KB];

   property p_char_flip;
      @(posedge sys_clk) disable iff (rst)
      (rise && cnt_reg == CW'(CHAR_DIV/2 - 1)) |=> (char_phase != $past(char_phase));
   endproperty
   a_char_flip: assert property (p_char_flip) else $error("char blink phase missed");

   property p_cursor_flip;
      @(posedge sys_clk) disable iff (rst)
      (rise && cnt_reg[KB:0] == {(KB+1){1'b1}}) |=> (cursor_phase != $past(cursor_phase));
   endproperty
   a_cursor_flip: assert property (p_cursor_flip) else $error("cursor phase missed");
endmodule // vac_blink

// file: hw/vac_attr_ctrl.sv
// vac_attr_ctrl: attribute controller, host port, palette and pixel output
`timescale 1ns/1ps
module vac_attr_ctrl
   import vac_pkg::*;
#(
   parameter int PAL_DEPTH = 16
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [15:0] io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   output logic      [7:0]  io_rdata,
   output logic             io_rvalid,
   input  wire logic        disp_active,
   input  wire logic [7:0]  text_char,
   input  wire logic [7:0]  text_attr,
   input  wire logic        font_dot,
   input  wire logic        ninth_col,
   input  wire logic        eighth_dot,
   input  wire logic        cursor_here,
   input  wire logic        underline_row,
   input  wire logic [3:0]  gfx_code,
   input  wire logic        vertical_retrace_tick,
   input  wire logic        line_cmp_match,
   input  wire logic        vsync,
   output logic      [3:0]  pan_amount,
   output logic      [7:0]  video_out,
   output logic             pix_strobe,
   output logic             secondary_red_out,
   output logic             secondary_green_intensity_out,
   output logic             secondary_blue_video_out,
   output logic             red_out,
   output logic             green_out,
   output logic             blue_out
);

   ////////////////////////////////////////////////////////////////////////
   // host port decode

   logic [5:0] index_reg;
   logic       index_data_toggle;
   logic [5:0] pal_q [PAL_DEPTH];
   logic [7:0] attribute_mode_reg;
   logic [7:0] border_reg;
   logic [3:0] pan_reg;
   logic [3:0] pixel_padding_reg;
   logic [7:0] rd_mux;
   logic       wr_port;
   logic       rd_index;
   logic       rd_data;
   logic       rd_status;
   logic       data_wr;
   logic [4:0] attr_sel;
   logic       palette_display_enable;

   // true when the index points at a palette entry
   function automatic logic is_pal(input logic [4:0] i);
      return i <= VAC_IDX_PAL_LAST;
   endfunction

   assign wr_port   = io_wr && io_addr == VAC_ADDR_ATTR_WR;
   assign rd_index  = io_rd && io_addr == VAC_ADDR_ATTR_WR;
   assign rd_data   = io_rd && io_addr == VAC_ADDR_ATTR_RD;
   assign rd_status = io_rd && (io_addr == VAC_ADDR_STAT_MONO ||
                                io_addr == VAC_ADDR_STAT_COLR);
   assign data_wr   = wr_port && index_data_toggle;
   assign attr_sel  = index_reg[4:0];
   assign palette_display_enable = index_reg[VAC_IDX_PAL_EN];

   ////////////////////////////////////////////////////////////////////////
   // index/data toggle and index register

   // status read wins: software relies on it to resynchronise
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         index_data_toggle <= 1'b0;
      end else if (rd_status) begin
         index_data_toggle <= 1'b0;
      end else if (wr_port) begin
         index_data_toggle <= !index_data_toggle;
      end
   end

   // bits seven and six are dropped, so they read zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         index_reg <= VAC_INDEX_RST;
      end else if (wr_port && !index_data_toggle) begin
         index_reg <= io_wdata[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // attribute registers

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         attribute_mode_reg <= VAC_MODE_RST;
         border_reg         <= VAC_BORDER_RST;
         pan_reg            <= VAC_PAN_RST;
         pixel_padding_reg  <= VAC_PAD_RST;
      end else if (data_wr) begin
         unique case (attr_sel)
            VAC_IDX_MODE:   attribute_mode_reg <= io_wdata & VAC_MODE_WMASK;
            VAC_IDX_BORDER: border_reg         <= io_wdata;
            VAC_IDX_PAN:    pan_reg            <= io_wdata[3:0];
            VAC_IDX_PAD:    pixel_padding_reg  <= io_wdata[3:0];
            default:        ;
         endcase
      end
   end

   // palette entries; host writes only while the display is off them
   generate
      for (genvar g = 0; g < PAL_DEPTH; g++) begin : g_pal
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               pal_q[g] <= VAC_PAL_RST;
            end else if (data_wr && is_pal(attr_sel) && !palette_display_enable &&
                         attr_sel[3:0] == 4'(g)) begin
               pal_q[g] <= io_wdata[5:0];
            end
         end
      end
   endgenerate

   // read mux; blocked palette and unmapped indices read zero
   always_comb begin
      rd_mux = 8'h00;
      if (is_pal(attr_sel)) begin
         if (!palette_display_enable) begin
            rd_mux = {2'b00, pal_q[attr_sel[3:0]]};
         end
      end else begin
         unique case (attr_sel)
            VAC_IDX_MODE:   rd_mux = attribute_mode_reg;
            VAC_IDX_BORDER: rd_mux = border_reg;
            VAC_IDX_PAN:    rd_mux = {4'h0, pan_reg};
            VAC_IDX_PAD:    rd_mux = {4'h0, pixel_padding_reg};
            default:        rd_mux = 8'h00;
         endcase
      end
   end

   // read data lands one cycle after the strobe; index and data reads never touch the toggle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         io_rdata  <= 8'h00;
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= rd_index || rd_data;
         if (rd_index) begin
            io_rdata <= {2'b00, index_reg};
         end else if (rd_data) begin
            io_rdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // blink and split-screen panning

   logic char_phase;
   logic cursor_phase;
   logic pan_zero_reg;

   vac_blink u_blink (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .retrace_in   (vertical_retrace_tick),
      .char_phase   (char_phase),
      .cursor_phase (cursor_phase)
   );

   // match sets, vertical sync clears; a match in the sync cycle wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pan_zero_reg <= 1'b0;
      end else if (line_cmp_match) begin
         pan_zero_reg <= 1'b1;
      end else if (vsync) begin
         pan_zero_reg <= 1'b0;
      end
   end

   assign pan_amount = (attribute_mode_reg[VAC_MODE_SPLIT] && pan_zero_reg) ?
                       4'h0 : pan_reg;

   ////////////////////////////////////////////////////////////////////////
   // colour code selection

   logic       text_graphics_select;
   logic       mono_attribute_select;
   logic       line_graphics_enable;
   logic       blink_enable;
   logic       wide_colour_mode;
   logic       upper_pair_source_select;
   logic       dot;
   logic       fg_on;
   logic [3:0] bg_code;
   logic [3:0] code;
   logic [5:0] pal_out;

   assign text_graphics_select     = attribute_mode_reg[VAC_MODE_TXGR];
   assign mono_attribute_select    = attribute_mode_reg[VAC_MODE_MONO];
   assign line_graphics_enable     = attribute_mode_reg[VAC_MODE_LGC];
   assign blink_enable             = attribute_mode_reg[VAC_MODE_BLNK];
   assign wide_colour_mode         = attribute_mode_reg[VAC_MODE_WIDE];
   assign upper_pair_source_select = attribute_mode_reg[VAC_MODE_SELV54];

   // text path; mono blanking ignores blink and intensity bits
   always_comb begin
      dot = font_dot;
      if (ninth_col) begin
         dot = line_graphics_enable && text_char[7:5] == VAC_LG_TOP &&
               eighth_dot;
      end
      if (mono_attribute_select) begin
         dot = ((text_attr & VAC_MONO_BLANK_MSK) != 8'h00) &&
               (dot || (text_attr[2:0] == VAC_MONO_ULINE && underline_row));
      end
      fg_on = (dot && !(blink_enable && text_attr[7] && !char_phase)) ||
              (cursor_here && cursor_phase);
      bg_code = blink_enable ? {1'b0, text_attr[6:4]} : text_attr[7:4];
      if (text_graphics_select) begin
         code = gfx_code ^ {blink_enable && char_phase, 3'b000};
      end else begin
         code = fg_on ? text_attr[3:0] : bg_code;
      end
   end

   assign pal_out = pal_q[code];

   ////////////////////////////////////////////////////////////////////////
   // pixel output stage

   logic       phase_reg;
   logic [3:0] hi_reg;

   // wide mode: first half-pixel is held, second completes the byte
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase_reg  <= 1'b0;
         hi_reg     <= 4'h0;
         video_out  <= 8'h00;
         pix_strobe <= 1'b0;
      end else begin
         phase_reg  <= wide_colour_mode && !phase_reg;
         pix_strobe <= !wide_colour_mode || phase_reg;
         if (!disp_active || !palette_display_enable) begin
            video_out <= border_reg;
         end else if (wide_colour_mode) begin
            if (!phase_reg) begin
               hi_reg <= pal_out[3:0];
            end else begin
               video_out <= {hi_reg, pal_out[3:0]};
            end
         end else begin
            video_out <= {pixel_padding_reg[3:2],
                          upper_pair_source_select ? pixel_padding_reg[1:0] :
                          pal_out[5:4],
                          pal_out[3:0]};
         end
      end
   end

   // colour pins follow the registered pixel
   assign secondary_red_out             = video_out[5];
   assign secondary_green_intensity_out = video_out[4];
   assign secondary_blue_video_out      = video_out[3];
   assign red_out                       = video_out[2];
   assign green_out                     = video_out[1];
   assign blue_out                      = video_out[0];

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_status_preset;
      @(posedge sys_clk) disable iff (rst)
      rd_status |=> !index_data_toggle;
   endproperty
   a_status_preset: assert property (p_status_preset) else $error("toggle not preset");

   property p_write_flip;
      @(posedge sys_clk) disable iff (rst)
      (wr_port && !rd_status) |=> index_data_toggle != $past(index_data_toggle);
   endproperty
   a_write_flip: assert property (p_write_flip) else $error("toggle did not flip");

   property p_read_keep;
      @(posedge sys_clk) disable iff (rst)
      (rd_index || rd_data) |=> $stable(index_data_toggle);
   endproperty
   a_read_keep: assert property (p_read_keep) else $error("read moved toggle");

   property p_index_read;
      @(posedge sys_clk) disable iff (rst)
      rd_index |=> io_rvalid && io_rdata == {2'b00, $past(index_reg)};
   endproperty
   a_index_read: assert property (p_index_read) else $error("index readback wrong");

   property p_pal_blocked;
      @(posedge sys_clk) disable iff (rst)
      (data_wr && palette_display_enable && is_pal(attr_sel))
         |=> pal_q[$past(attr_sel[3:0])] == $past(pal_q[attr_sel[3:0]]);
   endproperty
   a_pal_blocked: assert property (p_pal_blocked) else $error("palette written while shown");

   property p_colour_pins;
      @(posedge sys_clk) disable iff (rst)
      (disp_active && palette_display_enable && text_graphics_select && !blink_enable &&
       !wide_colour_mode && !upper_pair_source_select)
         |=> {secondary_red_out, secondary_green_intensity_out, secondary_blue_video_out,
              red_out, green_out, blue_out} == $past(pal_q[gfx_code]);
   endproperty
   a_colour_pins: assert property (p_colour_pins) else $error("colour pins mismatch");

   property p_border;
      @(posedge sys_clk) disable iff (rst)
      !disp_active |=> video_out == $past(border_reg);
   endproperty
   a_border: assert property (p_border) else $error("border colour missing");

   property p_pad_upper;
      @(posedge sys_clk) disable iff (rst)
      (disp_active && palette_display_enable && !wide_colour_mode)
         |=> video_out[7:6] == $past(pixel_padding_reg[3:2]) &&
             ($past(upper_pair_source_select) ->
              video_out[5:4] == $past(pixel_padding_reg[1:0]));
   endproperty
   a_pad_upper: assert property (p_pad_upper) else $error("upper video bits wrong");

   sequence s_wide_run;
      wide_colour_mode [*2];
   endsequence

   property p_wide_pace;
      @(posedge sys_clk) disable iff (rst)
      s_wide_run |=> pix_strobe != $past(pix_strobe);
   endproperty
   a_wide_pace: assert property (p_wide_pace) else $error("wide pixel pace wrong");

   property p_split_pan;
      @(posedge sys_clk) disable iff (rst)
      (attribute_mode_reg[VAC_MODE_SPLIT] && line_cmp_match && !data_wr)
         |=> pan_amount == 4'h0;
   endproperty
   a_split_pan: assert property (p_split_pan) else $error("pan not suppressed");

   property p_mode_rsvd;
      @(posedge sys_clk) disable iff (rst)
      data_wr && attr_sel == VAC_IDX_MODE |=> attribute_mode_reg[4] == 1'b0;
   endproperty
   a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode bit set");
endmodule // vac_attr_ctrl

// file: tb/vac_host_model.sv
// vac_host_model: host processor issuing byte-wide I/O reads and writes
`timescale 1ns/1ps
module vac_host_model
   import vac_pkg::*;
(
   input  wire logic        sys_clk,
   output logic      [15:0] io_addr,
   output logic      [7:0]  io_wdata,
   output logic             io_wr,
   output logic             io_rd
);
   initial begin
      io_addr = 16'h0000;
      io_wdata = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
   end
   // one-clock strobe; qualifiers held with it, then scrambled so no stale value lingers
   task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge sys_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= w;
      io_rd <= ~w;
      @(posedge sys_clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask
   // a status read before each sequence puts the toggle on the index
   task automatic sync(input logic mono);
      access(mono ? VAC_ADDR_STAT_MONO : VAC_ADDR_STAT_COLR, 8'h00, 1'b0);
   endtask
endmodule // vac_host_model

// file: tb/testbench.sv
// testbench: host port, palette, pan and blink checks of the attribute controller
`timescale 1ns/1ps
module testbench
   import vac_pkg::*;
   ;
   logic sys_clk = 1'b0, rst = 1'b1;
   logic [15:0] io_addr;
   logic [7:0]  io_wdata, io_rdata, text_char, text_attr, video_out, bdr, v0, v1;
   logic        io_wr, io_rd, io_rvalid, disp_active, font_dot, ninth_col, eighth_dot;
   logic        cursor_here, underline_row, vertical_retrace_tick, line_cmp_match, vsync;
   logic        pix_strobe, sr, sg, sb, r, g, b;
   logic [3:0]  gfx_code, pan_amount;
   logic [5:0]  pal [16];
   logic [7:0]  exp_q [$];
   logic [7:0]  px_q [$];
   logic        txt_on = 1'b0, txt_mono = 1'b0, txt_cur = 1'b0;
   logic [31:0] seed = 32'h139C;
   int          n_errors = 0, n_checks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #25 sys_clk = ~sys_clk;
   vac_host_model u_vac_host_model (.sys_clk(sys_clk), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));
   vac_attr_ctrl u_vac_attr_ctrl (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr),
      .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .disp_active(disp_active), .text_char(text_char),
      .text_attr(text_attr), .font_dot(font_dot), .ninth_col(ninth_col),
      .eighth_dot(eighth_dot), .cursor_here(cursor_here), .underline_row(underline_row),
      .gfx_code(gfx_code), .vertical_retrace_tick(vertical_retrace_tick),
      .line_cmp_match(line_cmp_match), .vsync(vsync), .pan_amount(pan_amount),
      .video_out(video_out), .pix_strobe(pix_strobe), .secondary_red_out(sr),
      .secondary_green_intensity_out(sg), .secondary_blue_video_out(sb),
      .red_out(r), .green_out(g), .blue_out(b));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // text inputs wander randomly; graphics paths must ignore them
   always @(posedge sys_clk) begin
      seed <= lfsr(seed);
      {text_char, text_attr, font_dot, ninth_col, eighth_dot} <= seed[18:0];
      {cursor_here, underline_row} <= seed[22:21];
   end
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // negedge sampling avoids racing the one-cycle read answer
   always @(negedge sys_clk) begin
      if (io_rvalid === 1'b1) begin
         if (exp_q.size() == 0)
            check("unexpected read", 8'hXX, io_rdata);
         else
            check("io_rdata", exp_q.pop_front(), io_rdata);
      end
   end
   // reference colour code of one text dot, blink off; cur is the cursor phase
   function automatic logic [3:0] txt_code(input logic mono, input logic cur);
      logic d;
      d = ninth_col ? (text_char[7:5] == VAC_LG_TOP && eighth_dot) : font_dot;
      if (mono)
         d = (text_attr & VAC_MONO_BLANK_MSK) != 8'h00 &&
             (d || (text_attr[2:0] == VAC_MONO_ULINE && underline_row));
      return (d || (cursor_here && cur)) ? text_attr[3:0] : text_attr[7:4];
   endfunction
   // text pixels: note what this cycle's inputs must show, check the oldest note
   always @(negedge sys_clk) begin
      if (!txt_on)
         px_q.delete();
      else begin
         if (pix_strobe === 1'b1 && px_q.size() > 0)
            check("text pixel", px_q.pop_front(), video_out);
         px_q.push_back({2'b11, pal[txt_code(txt_mono, txt_cur)]});
      end
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      u_vac_host_model.access(a, d, 1'b1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_vac_host_model.access(a, 8'h00, 1'b0);
   endtask
   task automatic setreg(input logic [7:0] i, input logic [7:0] d);
      u_vac_host_model.sync(1'b0);
      wr(VAC_ADDR_ATTR_WR, i);
      wr(VAC_ADDR_ATTR_WR, d);
   endtask
   task automatic getreg(input logic [7:0] i, input logic [7:0] e);
      u_vac_host_model.sync(1'b0);
      wr(VAC_ADDR_ATTR_WR, i);
      rd(VAC_ADDR_ATTR_RD, e);
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         vertical_retrace_tick <= 1'b1;
         @(posedge sys_clk);
         vertical_retrace_tick <= 1'b0;
      end
      settle();
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: whole run needs under a thousand cycles
   initial begin
      #(20000 * 50);
      n_errors++;
      final_report();
   end
   // main sequence
   initial begin
      {disp_active, vertical_retrace_tick, line_cmp_match, vsync} = 4'h0;
      gfx_code = 4'h0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      u_vac_host_model.sync(1'b1);
      wr(VAC_ADDR_ATTR_WR, 8'hD0);
      rd(VAC_ADDR_ATTR_WR, 8'h10);
      rd(VAC_ADDR_ATTR_RD, VAC_MODE_RST);
      wr(VAC_ADDR_ATTR_WR, 8'hFF);
      rd(VAC_ADDR_ATTR_RD, VAC_MODE_WMASK);
      wr(VAC_ADDR_ATTR_WR, 8'h11);
      rd(VAC_ADDR_ATTR_WR, 8'h11);
      $display("test toggle done");
      for (int i = 0; i < 16; i++) begin
         pal[i] = {seed[5:4], 4'(i)};
         setreg(8'(i), {seed[7:6], pal[i]});
      end
      for (int i = 0; i < 16; i++)
         getreg(8'(i), {2'b00, pal[i]});
      bdr = seed[7:0];
      setreg(8'h11, bdr);
      getreg(8'h11, bdr);
      getreg(8'h12, 8'h00);
      setreg(8'h23, 8'hFF);
      getreg(8'h23, 8'h00);
      getreg(8'h03, {2'b00, pal[3]});
      $display("test registers done");
      setreg(8'h30, 8'h01);
      setreg(8'h34, 8'h0E);
      disp_active <= 1'b1;
      for (int k = 0; k < 16; k++) begin
         @(posedge sys_clk);
         gfx_code <= 4'(k);
         settle();
         check("video_out", {2'b11, pal[k]}, video_out);
         check("colour pins", {2'b00, pal[k]}, {2'b00, sr, sg, sb, r, g, b});
         check("pix_strobe", 8'h01, {7'h00, pix_strobe});
      end
      setreg(8'h30, 8'h81);
      settle();
      check("video_out", {4'hE, pal[15][3:0]}, video_out);
      @(posedge sys_clk);
      gfx_code <= 4'h5;
      setreg(8'h30, 8'h41);
      settle();
      check("wide pixel", {pal[5][3:0], pal[5][3:0]}, video_out);
      v0 = {7'h00, pix_strobe};
      @(negedge sys_clk);
      check("wide pace", ~v0, {7'h7F, pix_strobe});
      @(posedge sys_clk);
      disp_active <= 1'b0;
      settle();
      check("border", bdr, video_out);
      $display("test pixels done");
      setreg(8'h33, 8'h05);
      setreg(8'h30, 8'h21);
      settle();
      check("pan", 8'h05, {4'h0, pan_amount});
      @(posedge sys_clk);
      line_cmp_match <= 1'b1;
      @(posedge sys_clk);
      line_cmp_match <= 1'b0;
      settle();
      check("pan", 8'h00, {4'h0, pan_amount});
      @(posedge sys_clk);
      vsync <= 1'b1;
      @(posedge sys_clk);
      vsync <= 1'b0;
      settle();
      check("pan", 8'h05, {4'h0, pan_amount});
      $display("test pan done");
      setreg(8'h30, 8'h09);
      disp_active <= 1'b1;
      gfx_code <= 4'h2;
      settle();
      v0 = video_out;
      ticks(16);
      v1 = video_out;
      check("blink pair", 8'h01, {7'h00, ({v0, v1} === {2'b11, pal[2], 2'b11, pal[10]})
         || ({v1, v0} === {2'b11, pal[2], 2'b11, pal[10]})});
      ticks(16);
      check("blink period", v0, video_out);
      $display("test blink done");
      // text modes: colour then mono, cursor phase off then on after eight retraces
      for (int m = 0; m < 4; m++) begin
         if (m == 2)
            ticks(8);
         setreg(8'h30, m[0] ? 8'h06 : 8'h04);
         txt_mono = m[0];
         txt_cur = m[1];
         txt_on = 1'b1;
         repeat (40) @(posedge sys_clk);
         txt_on = 1'b0;
      end
      $display("test text done");
      final_report();
   end
endmodule // testbench
